/* common/mafc_pkg.sv */
/*
  constants, register map and carrier structs of the mac address
  filter and control block.
  assumes a 40 MHz single clock and a 32-bit avalon-mm register bus.
*/
package mafc_pkg;

  // register indices; byte address is four times the index
  localparam logic [3:0] IDX_CONTROL    = 4'h1;
  localparam logic [3:0] IDX_ADDR_HIGH  = 4'h2;
  localparam logic [3:0] IDX_ADDR_LOW   = 4'h3;
  localparam logic [3:0] IDX_TABLE_HIGH = 4'h4;
  localparam logic [3:0] IDX_TABLE_LOW  = 4'h5;
  localparam logic [3:0] IDX_STATUS     = 4'hA;

  // control fields
  localparam int CTL_RX_ON_BIT    = 2;
  localparam int CTL_TX_ON_BIT    = 3;
  localparam int CTL_DEFER_CK_BIT = 5;
  localparam int CTL_PASS_ALL_BIT = 19;

  // status fields
  localparam int STS_INIT_BIT      = 0;
  localparam int STS_DEFERRING_BIT = 1;
  localparam int STS_ABORTS_LSB    = 8;

  // reset values
  localparam logic [31:0] RST_CONTROL   = 32'h00000000;
  localparam logic [15:0] RST_ADDR_HIGH = 16'hFFFF;
  localparam logic [31:0] RST_ADDR_LOW  = 32'h0FFFFFFF;
  localparam logic [31:0] RST_TABLE     = 32'h00000000;

  // deferral limit in bit times
  localparam logic [14:0] DEFER_LIMIT_BITS = 15'h5EE0;

  // eeprom byte locations of the station address
  localparam logic [2:0] EE_LOC_FIRST = 3'h1;
  localparam logic [2:0] EE_LOC_HIGH  = 3'h5;
  localparam logic [2:0] EE_LOC_LAST  = 3'h6;

  // destination address hashing
  localparam logic [31:0] CRC_POLY = 32'hEDB88320;
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
  localparam logic [2:0]  DA_BYTES = 3'h6;
  localparam int          HASH_LSB = 26;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [5:0]  address;
    logic [31:0] writeData;
    logic [3:0]  byteEnable;
  } mafc_bus_req_t;

  typedef struct packed {
    logic [31:0] readData;
    logic        waitRequest;
  } mafc_bus_rsp_t;

  typedef struct packed {
    logic       valid;
    logic [2:0] location;
    logic [7:0] data;
  } mafc_ee_byte_t;

  typedef struct packed {
    logic       valid;
    logic       start;
    logic [7:0] data;
  } mafc_rx_byte_t;

  typedef struct packed {
    logic valid;
    logic group;
    logic accept;
  } mafc_rx_verdict_t;

endpackage : mafc_pkg

/* hw/mafc_core.sv */
/*
  mac control and address filter: control and station address
  registers, eeprom address load, multicast hash table, receive
  address filtering and transmit deferral.
  assumes an avalon-mm master on the same clock, an eeprom controller
  that only offers bytes from a programmed part, and a carrier sense
  line from the phy that is asynchronous to this clock.
*/
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// R01: with check on, abort attempt after deferring over 24288 bit times.
// R02: deferral timer runs while a frame waits and carrier is sensed.
// R03: timer restarts from zero for each new deferral, never cumulative.
// R04: with check off, never abort; wait for carrier indefinitely.
// R05: control bit 3 set lets the transmitter send; cleared, sends none.
// R06: control bit 2 set lets the receiver accept; cleared, accepts none.
// R07: address high holds address bits 47..32 in 15..0; top reserved.
// R08: address loaded from eeprom only when a programmed part is found.
// R09: eeprom 1..4 fill address low bytes; 5 and 6 fill address high.
// R10: address low bits 7..0 is the first byte on the wire, high 15..8 last.
// R11: software writes the address only after power-on load completes.
// R12: six-bit index; top bit picks table word, five bits pick the bit.
// R13: a group frame passes when its indexed table bit is one.
// R14: pass-all-group set accepts every group frame regardless of table.
// R15: table high holds bits 63..32, low holds 31..0; both reset zero.
// R16: hash index taken from crc-32 over the destination address.
module mafc_core
  import mafc_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire mafc_bus_req_t busReq,
  output mafc_bus_rsp_t   busRsp,
  input  wire mafc_ee_byte_t eeByte,
  input  wire logic       eeInitDone,
  input  wire logic       phyCarrier,
  input  wire logic       bitTick,
  input  wire logic       txFrameReady,
  output logic            txStart,
  output logic            txDeferAbort,
  output logic            transmitterOn,
  output logic            receiverOn,
  input  wire mafc_rx_byte_t rxByte,
  output mafc_rx_verdict_t rxVerdict
);

  ////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic             txOn;
    logic             rxOn;
    logic             checkOn;
    logic             passAll;
    logic [15:0]      addrHigh;
    logic [31:0]      addrLow;
    logic [31:0]      tableHigh;
    logic [31:0]      tableLow;
    logic             initDone;
    logic [7:0]       abortCount;
    logic [2:0]       crsSync;
    logic             crsStable;
    logic [31:0]      crc;
    logic [2:0]       daCount;
    logic             group;
    logic             broadcast;
    logic             unicastHit;
    mafc_rx_verdict_t verdict;
    mafc_bus_rsp_t    rsp;
  } mafc_core_state_t;

  mafc_core_state_t state_reg;
  mafc_core_state_t state_next;

  logic        deferStart;
  logic        deferAbort;
  logic        deferring;
  logic [31:0] crcStep;
  logic [31:0] crcSeed;
  logic [47:0] stationAddr;
  logic [63:0] tableBits;
  logic [5:0]  hashIndex;
  logic [3:0]  regIndex;
  logic        busDone;
  logic        busFirst;

  ////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [31:0] mergeBytes(
    input logic [31:0] oldValue,
    input logic [31:0] newValue,
    input logic [3:0]  enables
  );
    logic [31:0] merged;
    merged = oldValue;
    for (int b = 0; b < 4; b++)
    begin
      if (enables[b])
        merged[b*8 +: 8] = newValue[b*8 +: 8];
    end
    return merged;
  endfunction : mergeBytes

  assign stationAddr = {state_reg.addrHigh, state_reg.addrLow};
  assign tableBits   = {state_reg.tableHigh, state_reg.tableLow}; // [R15]
  assign crcSeed     = (rxByte.start) ? CRC_INIT : state_reg.crc;
  assign hashIndex   = crcStep[HASH_LSB +: 6];                    // [R16]
  assign regIndex    = busReq.address[5:2];

  // first request cycle drops waitrequest; the next edge completes it
  assign busFirst = (busReq.read || busReq.write) && state_reg.rsp.waitRequest;
  assign busDone  = (busReq.read || busReq.write) && !state_reg.rsp.waitRequest;

  mafc_crc_step crcUnit (
    .crcIn  (crcSeed),
    .dataIn (rxByte.data),
    .crcOut (crcStep)
  );

  mafc_defer deferUnit (
    .clock      (clock),
    .rstn       (rstn),
    .frameReady (txFrameReady),
    .carrier    (state_reg.crsStable),
    .txOn       (state_reg.txOn),
    .checkOn    (state_reg.checkOn),
    .bitTick    (bitTick),
    .txStart    (deferStart),
    .deferAbort (deferAbort),
    .deferring  (deferring)
  );

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    logic [7:0]  expected;
    logic [31:0] ctlWord;
    logic        hashHit;
    expected = 8'h00;
    ctlWord  = 32'h00000000;
    hashHit  = 1'b0;
    state_next = state_reg;

    // carrier sense: change counts once stages two and three agree
    state_next.crsSync = {state_reg.crsSync[1:0], phyCarrier};
    if (state_reg.crsSync[1] == state_reg.crsSync[2])
      state_next.crsStable = state_reg.crsSync[2];

    // power-on address load
    if (eeInitDone)
      state_next.initDone = 1'b1;
    if (eeByte.valid && !state_reg.initDone)               // [R08]
    begin
      for (int b = 0; b < 4; b++)
      begin
        if (eeByte.location == EE_LOC_FIRST + 3'(b))
          state_next.addrLow[b*8 +: 8] = eeByte.data;     // [R09] [R10]
      end
      if (eeByte.location == EE_LOC_HIGH)
        state_next.addrHigh[7:0] = eeByte.data;           // [R09]
      if (eeByte.location == EE_LOC_LAST)
        state_next.addrHigh[15:8] = eeByte.data;          // [R09] [R10]
    end

    // deferral aborts are counted for software, wrapping at 255
    if (deferAbort)
      state_next.abortCount = state_reg.abortCount + 8'h01;

    // register bus
    ctlWord[CTL_RX_ON_BIT]    = state_reg.rxOn;
    ctlWord[CTL_TX_ON_BIT]    = state_reg.txOn;
    ctlWord[CTL_DEFER_CK_BIT] = state_reg.checkOn;
    ctlWord[CTL_PASS_ALL_BIT] = state_reg.passAll;

    state_next.rsp.waitRequest = 1'b1;
    if (busFirst)
    begin
      state_next.rsp.waitRequest = 1'b0;
      state_next.rsp.readData    = 32'h00000000;
      if (busReq.read)
      begin
        case (regIndex)
          IDX_CONTROL:    state_next.rsp.readData = ctlWord;
          IDX_ADDR_HIGH:  state_next.rsp.readData = {16'h0000,
                                                     state_reg.addrHigh};
          IDX_ADDR_LOW:   state_next.rsp.readData = state_reg.addrLow;
          IDX_TABLE_HIGH: state_next.rsp.readData = state_reg.tableHigh;
          IDX_TABLE_LOW:  state_next.rsp.readData = state_reg.tableLow;
          IDX_STATUS:
          begin
            state_next.rsp.readData[STS_INIT_BIT]      = state_reg.initDone;
            state_next.rsp.readData[STS_DEFERRING_BIT] = deferring;
            state_next.rsp.readData[STS_ABORTS_LSB +: 8] =
              state_reg.abortCount;
          end
          default:        state_next.rsp.readData = 32'h00000000;
        endcase
      end
    end

    if (busDone && busReq.write)
    begin
      case (regIndex)
        IDX_CONTROL:
        begin
          ctlWord = mergeBytes(ctlWord, busReq.writeData, busReq.byteEnable);
          state_next.rxOn    = ctlWord[CTL_RX_ON_BIT];
          state_next.txOn    = ctlWord[CTL_TX_ON_BIT];
          state_next.checkOn = ctlWord[CTL_DEFER_CK_BIT];
          state_next.passAll = ctlWord[CTL_PASS_ALL_BIT];
        end
        IDX_ADDR_HIGH:
        begin
          // held off until the power-on load has finished
          if (state_reg.initDone)                          // [R11]
            state_next.addrHigh = 16'(mergeBytes({16'h0000,
              state_reg.addrHigh}, busReq.writeData,
              busReq.byteEnable));                         // [R07]
        end
        IDX_ADDR_LOW:
        begin
          if (state_reg.initDone)                          // [R11]
            state_next.addrLow = mergeBytes(state_reg.addrLow,
              busReq.writeData, busReq.byteEnable);
        end
        IDX_TABLE_HIGH:
          state_next.tableHigh = mergeBytes(state_reg.tableHigh,
            busReq.writeData, busReq.byteEnable);
        IDX_TABLE_LOW:
          state_next.tableLow = mergeBytes(state_reg.tableLow,
            busReq.writeData, busReq.byteEnable);
        default:
          state_next.tableLow = state_reg.tableLow;
      endcase
    end

    // receive destination address filter
    state_next.verdict.valid = 1'b0;
    if (rxByte.valid && (rxByte.start || state_reg.daCount != 3'h0))
    begin
      if (rxByte.start)
      begin
        expected              = stationAddr[7:0];
        state_next.daCount    = 3'h1;
        state_next.group      = rxByte.data[0];
        state_next.broadcast  = (rxByte.data == 8'hFF);
        state_next.unicastHit = (rxByte.data == expected); // [R10]
      end
      else
      begin
        expected = stationAddr[state_reg.daCount*8 +: 8];
        state_next.daCount    = state_reg.daCount + 3'h1;
        state_next.broadcast  = state_reg.broadcast &&
                                (rxByte.data == 8'hFF);
        state_next.unicastHit = state_reg.unicastHit &&
                                (rxByte.data == expected);
      end
      state_next.crc = crcStep;                            // [R16]
      if (state_next.daCount == DA_BYTES)
      begin
        // table word chosen by the top index bit, bit by the rest
        hashHit = tableBits[hashIndex];                    // [R12]
        state_next.daCount       = 3'h0;
        state_next.verdict.valid = 1'b1;
        state_next.verdict.group = state_next.group;
        if (!state_reg.rxOn)
          state_next.verdict.accept = 1'b0;                // [R06]
        else if (state_next.group)
          state_next.verdict.accept = state_next.broadcast ||
                                      state_reg.passAll || // [R14]
                                      hashHit;             // [R13]
        else
          state_next.verdict.accept = state_next.unicastHit;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      state_reg                 <= '0;
      state_reg.txOn            <= RST_CONTROL[CTL_TX_ON_BIT];
      state_reg.rxOn            <= RST_CONTROL[CTL_RX_ON_BIT];
      state_reg.checkOn         <= RST_CONTROL[CTL_DEFER_CK_BIT];
      state_reg.passAll         <= RST_CONTROL[CTL_PASS_ALL_BIT];
      state_reg.addrHigh        <= RST_ADDR_HIGH;
      state_reg.addrLow         <= RST_ADDR_LOW;
      state_reg.tableHigh       <= RST_TABLE;                // [R15]
      state_reg.tableLow        <= RST_TABLE;                // [R15]
      state_reg.crc             <= CRC_INIT;
      state_reg.rsp.waitRequest <= 1'b1;
    end
    else
      state_reg <= state_next;
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign busRsp        = state_reg.rsp;
  assign transmitterOn = state_reg.txOn;                   // [R05]
  assign receiverOn    = state_reg.rxOn;                   // [R06]
  assign txStart       = deferStart;
  assign txDeferAbort  = deferAbort;
  assign rxVerdict     = state_reg.verdict;

endmodule : mafc_core
`default_nettype wire

/* hw/mafc_crc_step.sv */
/*
  one byte step of the reflected crc-32 used for address hashing.
  assumes bytes arrive least significant bit first, as on the wire.
*/
`timescale 1ns/10ps
`default_nettype none
module mafc_crc_step
  import mafc_pkg::*;
(
  input  wire logic [31:0] crcIn,
  input  wire logic [7:0]  dataIn,
  output logic [31:0]      crcOut
);

  always_comb
  begin
    crcOut = crcIn;
    for (int i = 0; i < 8; i++)
    begin
      if (crcOut[0] ^ dataIn[i])
        crcOut = (crcOut >> 1) ^ CRC_POLY;
      else
        crcOut = crcOut >> 1;
    end
  end

endmodule : mafc_crc_step
`default_nettype wire

/* hw/mafc_defer.sv */
/*
  transmit deferral timer: grants the start of a frame once carrier
  clears and aborts an attempt held off too long.
  assumes bitTick pulses once per bit time on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
module mafc_defer
  import mafc_pkg::*;
(
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic frameReady,
  input  wire logic carrier,
  input  wire logic txOn,
  input  wire logic checkOn,
  input  wire logic bitTick,
  output logic      txStart,
  output logic      deferAbort,
  output logic      deferring
);

  typedef struct packed {
    logic [14:0] count;
    logic        start;
    logic        abort;
    logic        deferring;
  } mafc_defer_state_t;

  mafc_defer_state_t state_reg;
  mafc_defer_state_t state_next;

  always_comb
  begin
    state_next           = state_reg;
    state_next.start     = 1'b0;
    state_next.abort     = 1'b0;
    state_next.deferring = frameReady && txOn && carrier;
    if (!frameReady || !txOn)
      state_next.count = '0;
    else if (!carrier)
    begin
      state_next.start = 1'b1;                           // [R05]
      state_next.count = '0;                             // [R03]
    end
    else if (bitTick && checkOn)                         // [R02] [R04]
    begin
      if (state_reg.count == DEFER_LIMIT_BITS)
      begin
        state_next.abort = 1'b1;                         // [R01]
        state_next.count = '0;
      end
      else
        state_next.count = state_reg.count + 15'h0001;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign txStart    = state_reg.start;
  assign deferAbort = state_reg.abort;
  assign deferring  = state_reg.deferring;

endmodule : mafc_defer
`default_nettype wire

/* tb/mafc_core_properties.sv */
/*
  concurrent checks on the mafc_core ports.
  assumes the bind below and the package constants.
*/
`timescale 1ns/10ps
`default_nettype none
module mafc_core_properties
  import mafc_pkg::*;
(
  input wire logic             clock,
  input wire logic             rstn,
  input wire mafc_bus_req_t    busReq,
  input wire mafc_bus_rsp_t    busRsp,
  input wire logic             bitTick,
  input wire logic             txFrameReady,
  input wire logic             txStart,
  input wire logic             txDeferAbort,
  input wire logic             transmitterOn,
  input wire logic             receiverOn,
  input wire mafc_rx_byte_t    rxByte,
  input wire mafc_rx_verdict_t rxVerdict
);
  logic        ack;
  logic [31:0] ctlReg;
  logic [15:0] tickReg;

  assign ack = !busRsp.waitRequest;

  // shadow of control so flags can be judged against software intent
  always_ff @(posedge clock)
  begin
    if (!rstn)
      ctlReg <= RST_CONTROL;
    else if (ack && busReq.write && busReq.address[5:2] == IDX_CONTROL)
      for (int b = 0; b < 4; b++)
        if (busReq.byteEnable[b])
          ctlReg[8*b +: 8] <= busReq.writeData[8*b +: 8];
  end

  // ticks seen since the frame began waiting; falls one below the real count when a tick comes in the cycle after an abort
  always_ff @(posedge clock)
  begin
    if (!rstn || !txFrameReady || txStart || txDeferAbort)
      tickReg <= 16'h0000;
    else if (bitTick)
      tickReg <= tickReg + 16'h0001;
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  AST_ONE_WAIT:
    assert property ((busReq.read || busReq.write) && !ack |=> ack)
    else $error("bus request not answered next cycle");
  AST_ACK_PULSE:
    assert property (ack |=> !ack)
    else $error("waitrequest low for more than one cycle");
  AST_HIGH_RESERVED:
    assert property (ack && busReq.read && busReq.address[5:2] ==
      IDX_ADDR_HIGH |-> busRsp.readData[31:16] == 16'h0000)
    else $error("address high reserved bits not zero");
  AST_ON_MIRROR:
    assert property (transmitterOn == ctlReg[CTL_TX_ON_BIT] &&
      receiverOn == ctlReg[CTL_RX_ON_BIT])
    else $error("enable outputs differ from control");
  AST_START_CAUSE:
    assert property (txStart |-> $past(transmitterOn) && $past(txFrameReady))
    else $error("start without frame or with transmitter off");
  AST_ABORT_LATE:
    assert property (txDeferAbort |-> tickReg > {1'b0, DEFER_LIMIT_BITS})
    else $error("deferral abort before limit");
  AST_ABORT_PULSE:
    assert property (txDeferAbort |=> !txDeferAbort)
    else $error("deferral abort longer than one cycle");
  AST_NO_ABORT_UNCHECKED:
    assert property (!ctlReg[CTL_DEFER_CK_BIT] &&
      !$past(ctlReg[CTL_DEFER_CK_BIT]) |-> !txDeferAbort)
    else $error("abort with deferral check off");
  AST_RX_OFF:
    assert property (rxVerdict.valid && !$past(receiverOn)
      |-> !rxVerdict.accept)
    else $error("frame accepted with receiver off");
  AST_PASS_ALL:
    assert property (rxVerdict.valid && rxVerdict.group && $past(receiverOn)
      && $past(ctlReg[CTL_PASS_ALL_BIT]) |-> rxVerdict.accept)
    else $error("group frame refused with pass all set");
  AST_VERDICT_TIME:
    assert property (rxVerdict.valid |-> $past(rxByte.valid)
      ##1 !rxVerdict.valid)
    else $error("verdict not a pulse after a byte");
endmodule : mafc_core_properties
////////////////////////////////////////////////////////////////////////////
bind mafc_core mafc_core_properties u_mafc_core_properties (
  .clock(clock), .rstn(rstn), .busReq(busReq), .busRsp(busRsp),
  .bitTick(bitTick), .txFrameReady(txFrameReady), .txStart(txStart),
  .txDeferAbort(txDeferAbort), .transmitterOn(transmitterOn),
  .receiverOn(receiverOn), .rxByte(rxByte), .rxVerdict(rxVerdict)
);
`default_nettype wire

/* tb/mafc_phy_model.sv */
/*
  phy stand-in: carrier sense and destination address bytes.
  assumes the bench drives lineBusy and calls sendDa.
*/
`timescale 1ns/10ps
`default_nettype none
module mafc_phy_model
  import mafc_pkg::*;
(
  input  wire logic     clock,
  input  wire logic     lineBusy,
  output logic          carrier,
  output mafc_rx_byte_t rxByte
);
  // carrier has no relation to the clock edge of the block
  assign carrier = lineBusy;

  initial
    rxByte = '0;

  // first wire byte first; gap idles between bytes for a slow link
  task automatic sendDa(input logic [47:0] da, input int gap);
    for (int k = 0; k < 6; k++)
    begin
      @(posedge clock);
      rxByte <= '{1'b1, k == 0, da[47 - 8*k -: 8]};
      // no idle after the sixth byte, so the verdict pulse is not missed
      repeat (k < 5 ? gap : 0)
      begin
        @(posedge clock);
        rxByte <= '{1'b0, 1'b0, ~rxByte.data};
      end
    end
    @(posedge clock);
    // released bytes show junk, never the last value
    rxByte <= '{1'b0, 1'b0, ~rxByte.data};
  endtask : sendDa
endmodule : mafc_phy_model
`default_nettype wire

/* tb/tb_top.sv */
/*
  bench for mafc_core: registers, eeprom load, filter, deferral.
  assumes the bound checker and the phy stand-in.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import mafc_pkg::*;
;
  logic             clock = 1'b0;
  logic             rstn = 1'b0;
  mafc_bus_req_t    busReq = '0;
  mafc_bus_rsp_t    busRsp;
  mafc_ee_byte_t    eeByte = '0;
  logic             eeInitDone = 1'b0;
  logic             lineBusy = 1'b0;
  logic             phyCarrier;
  logic             bitTick = 1'b0;
  logic             txFrameReady = 1'b0;
  logic             txStart;
  logic             txDeferAbort;
  logic             transmitterOn;
  logic             receiverOn;
  mafc_rx_byte_t    rxByte;
  mafc_rx_verdict_t rxVerdict;
  int               numErrors = 0;
  int               checkCount = 0;
  int               n;
  logic             ab;
  logic [63:0]      tbl;

  always #12.5 clock = ~clock;

  mafc_core u_mafc_core (
    .clock(clock), .rstn(rstn), .busReq(busReq), .busRsp(busRsp),
    .eeByte(eeByte), .eeInitDone(eeInitDone), .phyCarrier(phyCarrier),
    .bitTick(bitTick), .txFrameReady(txFrameReady), .txStart(txStart),
    .txDeferAbort(txDeferAbort), .transmitterOn(transmitterOn),
    .receiverOn(receiverOn), .rxByte(rxByte), .rxVerdict(rxVerdict)
  );
  mafc_phy_model u_mafc_phy_model (
    .clock(clock), .lineBusy(lineBusy), .carrier(phyCarrier),
    .rxByte(rxByte)
  );
////////////////////////////////////////////////////////////////////////////
  task automatic printVerdict;
    $display("checks %0d mismatches %0d", checkCount, numErrors);
    if (numErrors == 0 && checkCount > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : printVerdict

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checkCount++;
    if (got !== exp)
    begin
      numErrors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [3:0] idx,
                     input logic [31:0] wd, output logic [31:0] rd);
    int k;
    k = 0;
    busReq <= '{~wr, wr, {idx, 2'b00}, wd, 4'hF};
    @(posedge clock);
    while (busRsp.waitRequest !== 1'b0 && k < 50)
    begin
      @(posedge clock);
      k++;
    end
    rd = busRsp.readData;
    busReq.read <= 1'b0;
    busReq.write <= 1'b0;
    @(posedge clock);
    chk("bus answer", 32'h00000001, k < 50);
    if (k == 50)
      printVerdict();
  endtask : bus

  task automatic wr(input logic [3:0] idx, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, idx, d, x);
  endtask : wr

  task automatic rdChk(input logic [3:0] idx, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, idx, 32'h00000000, x);
    chk($sformatf("register %h", idx), exp, x);
  endtask : rdChk

  // reflected crc over the wire bit order, lsb of each byte first
  function automatic logic [5:0] hashOf(input logic [47:0] da);
    logic [31:0] c;
    c = CRC_INIT;
    for (int k = 0; k < 6; k++)
      for (int j = 0; j < 8; j++)
        c = (c[0] ^ da[40 - 8*k + j]) ? (c >> 1) ^ CRC_POLY : c >> 1;
    return c[31:26];
  endfunction : hashOf

  task automatic frame(input logic [47:0] da, input int gap,
                       input logic exp);
    int k;
    k = 0;
    u_mafc_phy_model.sendDa(da, gap);
    while (rxVerdict.valid !== 1'b1 && k < 20)
    begin
      @(posedge clock);
      k++;
    end
    chk("verdict seen", 32'h00000001, k < 20);
    if (k == 20)
      printVerdict();
    chk($sformatf("accept %h", da), {31'h0, exp}, rxVerdict.accept);
  endtask : frame

  task automatic watch(input int lim);
    n = 0;
    while (txStart !== 1'b1 && txDeferAbort !== 1'b1 && n < lim)
    begin
      @(posedge clock);
      n++;
    end
    ab = txDeferAbort;
  endtask : watch
////////////////////////////////////////////////////////////////////////////
  task automatic testRegs;
    rdChk(IDX_CONTROL, 32'h00000000);
    rdChk(IDX_ADDR_HIGH, 32'h0000FFFF);
    rdChk(IDX_ADDR_LOW, 32'h0FFFFFFF);
    rdChk(IDX_TABLE_HIGH, 32'h00000000);
    rdChk(IDX_TABLE_LOW, 32'h00000000);
    rdChk(4'hF, 32'h00000000);
    $display("registers test done");
  endtask : testRegs

  task automatic testEeprom;
    for (int i = 1; i < 8; i++)
    begin
      if (i == 7)
        eeInitDone <= 1'b1;
      eeByte <= '{1'b1, i[2:0], 8'h12 + 8'h22 * (i - 1)};
      @(posedge clock);
      eeByte.valid <= 1'b0;
      @(posedge clock);
    end
    rdChk(IDX_ADDR_LOW, 32'h78563412);
    rdChk(IDX_ADDR_HIGH, 32'h0000BC9A);
    // software may rewrite only after init; top half stays reserved
    wr(IDX_ADDR_HIGH, 32'hABCD5A5A);
    rdChk(IDX_ADDR_HIGH, 32'h00005A5A);
    wr(IDX_ADDR_HIGH, 32'h0000BC9A);
    $display("eeprom test done");
  endtask : testEeprom

  task automatic testRx;
    wr(IDX_CONTROL, 32'h00000008);
    chk("tx on", 32'h00000002, {transmitterOn, receiverOn});
    frame(48'h123456789ABC, 0, 1'b0);
    wr(IDX_CONTROL, 32'h00000004);
    chk("rx on", 32'h00000001, {transmitterOn, receiverOn});
    rdChk(IDX_CONTROL, 32'h00000004);
    frame(48'h123456789ABC, 2, 1'b1);
    frame(48'h123456789ABD, 0, 1'b0);
    frame(48'hBC9A78563412, 0, 1'b0);
    tbl = 64'h1 << hashOf(48'h01005E000001);
    wr(IDX_TABLE_HIGH, tbl[63:32]);
    wr(IDX_TABLE_LOW, tbl[31:0]);
    frame(48'h01005E000001, 0, 1'b1);
    wr(IDX_TABLE_HIGH, ~tbl[63:32]);
    wr(IDX_TABLE_LOW, ~tbl[31:0]);
    rdChk(IDX_TABLE_HIGH, ~tbl[63:32]);
    frame(48'h01005E000001, 0, 1'b0);
    wr(IDX_CONTROL, 32'h00080004);
    frame(48'h01005E000001, 1, 1'b1);
    $display("receive test done");
  endtask : testRx

  task automatic testDefer;
    wr(IDX_CONTROL, 32'h00000000);
    bitTick <= 1'b1;
    txFrameReady <= 1'b1;
    watch(20);
    chk("start with tx off", 32'h00000014, n);
    wr(IDX_CONTROL, 32'h00000028);
    watch(10);
    chk("start with tx on", 32'h00000001, txStart);
    for (int a = 0; a < 2; a++)
    begin
      txFrameReady <= 1'b0;
      lineBusy <= 1'b1;
      repeat (6) @(posedge clock);
      txFrameReady <= 1'b1;
      watch(a == 0 ? 30000 : 10000);
      if (a == 0)
      begin
        chk("abort seen", 32'h00000001, ab);
        chk("abort time", 32'h00000001, n >= 24289 && n <= 24293);
      end
    end
    chk("partial deferral", 32'h00002710, n);
    lineBusy <= 1'b0;
    watch(10);
    chk("start after carrier", 32'h00000001, txStart);
    txFrameReady <= 1'b0;
    lineBusy <= 1'b1;
    repeat (6) @(posedge clock);
    txFrameReady <= 1'b1;
    watch(30000);
    chk("fresh deferral", 32'h00000001, n >= 24289 && ab);
    txFrameReady <= 1'b0;
    wr(IDX_CONTROL, 32'h00000008);
    txFrameReady <= 1'b1;
    watch(24400);
    chk("no abort unchecked", 32'h00005F50, n);
    txFrameReady <= 1'b0;
    lineBusy <= 1'b0;
    $display("deferral test done");
  endtask : testDefer

  initial
  begin
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    testRegs();
    testEeprom();
    testRx();
    testDefer();
    printVerdict();
  end
endmodule : tb_top
`default_nettype wire
